// *** design/csp_port.sv ***
// Purpose: codec serial port pin logic with APB register access
// Assumes: shift clock and all pins are asynchronous to pclk
// Notes: the device frames transfers; the partner follows the frame syncs
//
// Function
// - host shifts sample and control bits in, each bit timed by shift clock.
// - device shifts sample bits out, each bit timed by shift clock.
// - dual-word mode drives control bit ten onto its output pin.
// - reset clears control bit ten, so its pin starts low.
// - bit ten pin follows the bit at once, no frame delay.
// - word mode pulses inbound done strobe low after all 16 bits.
// - byte mode holds inbound strobe low from first byte to second byte.
// - dual-word mode forwards aux data pin to output line, framed by aux sync.
// - dual-word mode enables aux sync and control pins, disables strobes.
// - strap to positive supply selects word/byte mode with strobes active.
// - word/byte mode reads the shared pin as word or byte select.
// - input-select bit one picks aux analog inputs, zero the primary ones.
// - aux frame sync stays low exactly 16 shift clock periods.
// - aux sync high in primary frames, equals inbound sync in secondary.
// - dual-word mode drives bit eleven on second pin, reset clear, immediate.
`timescale 1ns/1ps
`default_nettype none
module csp_port
    import csp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [csp_pkg::APB_AW-1:0] paddr,
    input wire logic [csp_pkg::APB_DW-1:0] pwdata,
    output logic [csp_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic shift_clk,
    input wire logic serial_in_line,
    output logic serial_out_line,
    output logic inbound_frame_sync,
    output logic outbound_frame_sync,
    input wire logic aux_serial_data_pin,
    input wire logic wordbyte_strap,
    input wire logic aux_frame_sync_i,
    output logic aux_frame_sync_o,
    output logic aux_frame_sync_oe,
    output logic ctrl_bit10_pin,
    output logic ctrl_bit11_pin,
    output logic inbound_done_strobe,
    output logic outbound_done_strobe,
    output logic aux_input_sel
);
    import csp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and shift clock edges
    logic [4:0] pin_raw, pin_q;
    logic sclk_q, sin_q, aux_q, strap_q, wsel_q;
    logic sclk_d_ff, sclk_rise, sclk_fall, dual_mode;
    assign pin_raw = {shift_clk, serial_in_line, aux_serial_data_pin,
                      wordbyte_strap, aux_frame_sync_i};
    csp_sync #(.W(5)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pin_raw),
        .q(pin_q)
    );
    assign {sclk_q, sin_q, aux_q, strap_q, wsel_q} = pin_q;
    assign sclk_rise = sclk_q & ~sclk_d_ff;
    assign sclk_fall = ~sclk_q & sclk_d_ff;
    assign dual_mode = ~strap_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial shifters
    csp_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt, seg_last;
    logic fs_ff, nxt_fs, fsr_ff, nxt_fsr, fsd_ff, nxt_fsd;
    logic sec_ff, nxt_sec, byte_ff, nxt_byte, first_ff, nxt_first;
    logic mid_ff, nxt_mid, strobe_ff, nxt_strobe;
    logic sec_pend_ff, nxt_sec_pend, sout_ff, nxt_sout;
    logic pin10_ff, pin11_ff, insel_ff, oe_ff;
    logic [WORD_BITS-1:0] rx_word_ff, nxt_rx_word, ctlw_ff, nxt_ctlw;
    logic [WORD_BITS-1:0] rx_q, tx_q, tx_word_ff;
    logic tx_msb, tx_load, tx_shift, rx_shift, ev_word, ev_ctrl, run_ff;
    // inbound bits are taken on the falling shift clock edge
    assign rx_shift = sclk_fall & (state_ff == CSP_XFER);
    csp_shift #(.W(WORD_BITS)) u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .load(1'b0),
        .load_val(TXWORD_RESET),
        .shift_en(rx_shift),
        .ser_in(sin_q),
        .par_q(rx_q),
        .msb()
    );
    csp_shift #(.W(WORD_BITS)) u_tx (
        .pclk(pclk),
        .presetn(presetn),
        .load(tx_load),
        .load_val(tx_word_ff),
        .shift_en(tx_shift),
        .ser_in(1'b0),
        .par_q(tx_q),
        .msb(tx_msb)
    );

    ////////////////////////////////////////////////////////////////////////
    // frame sequencer: steps on rising shift clock edges; forwarded aux data follows its pin every pclk
    assign seg_last = (byte_ff & first_ff) ? LAST_BYTE_BIT : LAST_WORD_BIT;
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_fs = fs_ff;
        nxt_sec = sec_ff;
        nxt_byte = byte_ff;
        nxt_first = first_ff;
        nxt_mid = mid_ff;
        nxt_strobe = strobe_ff;
        nxt_sec_pend = sec_pend_ff;
        nxt_rx_word = rx_word_ff;
        nxt_ctlw = ctlw_ff;
        tx_load = 1'b0;
        tx_shift = 1'b0;
        ev_word = 1'b0;
        ev_ctrl = 1'b0;
        if (sclk_rise) begin
            unique case (state_ff)
                CSP_IDLE: begin
                    if (run_ff) begin
                        nxt_state = CSP_XFER;
                        nxt_fs = 1'b0;
                        nxt_cnt = CNT_ZERO;
                        nxt_sec = sec_pend_ff;
                        nxt_sec_pend = 1'b0;
                        // width select is ignored in dual-word mode
                        nxt_byte = ~dual_mode & ~wsel_q;
                        nxt_first = 1'b1;
                        tx_load = 1'b1;
                    end
                end
                CSP_XFER: begin
                    if (cnt_ff == seg_last) begin
                        nxt_fs = 1'b1;
                        nxt_state = CSP_HOLD;
                        if (byte_ff & first_ff) begin
                            nxt_first = 1'b0;
                            nxt_mid = 1'b1;
                            nxt_strobe = 1'b0;
                        end else begin
                            nxt_mid = 1'b0;
                            // byte mode: release; word mode: start pulse
                            nxt_strobe = byte_ff | dual_mode;
                            if (sec_ff) begin
                                nxt_ctlw = rx_q;
                                ev_ctrl = 1'b1;
                            end else begin
                                nxt_rx_word = rx_q;
                                nxt_sec_pend = rx_q[1:0] == SEC_REQ_CODE;
                                ev_word = 1'b1;
                            end
                        end
                    end else begin
                        nxt_cnt = cnt_ff + CNT_ONE;
                        tx_shift = 1'b1;
                    end
                end
                CSP_HOLD: begin
                    if (mid_ff) begin
                        // second byte follows one shift period later
                        nxt_state = CSP_XFER;
                        nxt_fs = 1'b0;
                        nxt_cnt = SECOND_BYTE_BIT;
                        nxt_mid = 1'b0;
                        tx_shift = 1'b1;
                    end else begin
                        nxt_state = CSP_IDLE;
                        nxt_strobe = 1'b1;
                    end
                end
            endcase
        end
    end
    always_comb begin
        // secondary frames use the inbound sync only; outbound stays high
        nxt_fsr = nxt_sec | nxt_fs;
        nxt_fsd = (dual_mode & nxt_sec) ? nxt_fs : 1'b1;
        nxt_sout = 1'b0;
        if (state_ff == CSP_XFER) begin
            if (sec_ff) begin
                nxt_sout = dual_mode & aux_q;
            end else begin
                nxt_sout = tx_msb;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= CSP_IDLE;
            cnt_ff <= CNT_ZERO;
            fs_ff <= 1'b1;
            fsr_ff <= 1'b1;
            fsd_ff <= 1'b1;
            sec_ff <= 1'b0;
            byte_ff <= 1'b0;
            first_ff <= 1'b0;
            mid_ff <= 1'b0;
            strobe_ff <= 1'b1;
            sec_pend_ff <= 1'b0;
            sout_ff <= 1'b0;
            rx_word_ff <= TXWORD_RESET;
            ctlw_ff <= CTLW_RESET;
            pin10_ff <= 1'b0;
            pin11_ff <= 1'b0;
            insel_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            fs_ff <= nxt_fs;
            fsr_ff <= nxt_fsr;
            fsd_ff <= nxt_fsd;
            sec_ff <= nxt_sec;
            byte_ff <= nxt_byte;
            first_ff <= nxt_first;
            mid_ff <= nxt_mid;
            strobe_ff <= nxt_strobe;
            sec_pend_ff <= nxt_sec_pend;
            sout_ff <= nxt_sout;
            rx_word_ff <= nxt_rx_word;
            ctlw_ff <= nxt_ctlw;
            // pins follow the new word in the same cycle it is stored
            pin10_ff <= dual_mode & nxt_ctlw[CTLW_BIT_TEN];
            pin11_ff <= dual_mode & nxt_ctlw[CTLW_BIT_ELEVEN];
            insel_ff <= nxt_ctlw[CTLW_INSEL_BIT];
            oe_ff <= dual_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, registers and interrupt
    logic [IRQ_BITS-1:0] status_ff, nxt_status, mask_ff, nxt_mask;
    logic [IRQ_BITS-1:0] events, w1c;
    logic [APB_DW-1:0] prdata_ff, nxt_prdata;
    logic pready_ff, pslverr_ff, nxt_pslverr, irq_ff, nxt_run, setup, wr_en;
    logic [WORD_BITS-1:0] nxt_tx_word;
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_ff & pwrite;
    always_comb begin
        events = '0;
        events[IRQ_WORD_BIT] = ev_word;
        events[IRQ_CTRL_BIT] = ev_ctrl;
        w1c = '0;
        nxt_run = run_ff;
        nxt_tx_word = tx_word_ff;
        nxt_mask = mask_ff;
        if (wr_en) begin
            unique case (paddr)
                REG_CTRL: nxt_run = pwdata[CTRL_RUN_BIT];
                REG_TXWORD: nxt_tx_word = pwdata[WORD_BITS-1:0];
                REG_STATUS: w1c = pwdata[IRQ_BITS-1:0];
                REG_MASK: nxt_mask = pwdata[IRQ_BITS-1:0];
                default: ;
            endcase
        end
        // an event in the clearing cycle survives the clear
        nxt_status = (status_ff & ~w1c) | events;
    end
    always_comb begin
        nxt_prdata = prdata_ff;
        nxt_pslverr = 1'b0; // error stands in the access cycle only
        if (setup) begin
            nxt_prdata = '0;
            nxt_pslverr = 1'b0;
            unique case (paddr)
                REG_CTRL: nxt_prdata[CTRL_RUN_BIT] = run_ff;
                REG_TXWORD: nxt_prdata[WORD_BITS-1:0] = tx_word_ff;
                REG_RXWORD: nxt_prdata[WORD_BITS-1:0] = rx_word_ff;
                REG_CTLWORD: nxt_prdata[WORD_BITS-1:0] = ctlw_ff;
                REG_STATUS: nxt_prdata[IRQ_BITS-1:0] = status_ff;
                REG_MASK: nxt_prdata[IRQ_BITS-1:0] = mask_ff;
                REG_STATE: nxt_prdata[5:0] = {dual_mode, byte_ff,
                    sec_pend_ff, sec_ff, state_ff};
                default: nxt_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff <= 1'b0;
            tx_word_ff <= TXWORD_RESET;
            status_ff <= IRQ_RESET;
            mask_ff <= IRQ_RESET;
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            run_ff <= nxt_run;
            tx_word_ff <= nxt_tx_word;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            prdata_ff <= nxt_prdata;
            // ready rises for the access cycle only: no wait states
            pready_ff <= setup;
            pslverr_ff <= nxt_pslverr;
            irq_ff <= |(nxt_status & nxt_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign serial_out_line = sout_ff;
    assign inbound_frame_sync = fs_ff;
    assign outbound_frame_sync = fsr_ff;
    assign aux_frame_sync_o = fsd_ff;
    // aux sync pin is an output only in dual-word mode
    assign aux_frame_sync_oe = oe_ff;
    assign ctrl_bit10_pin = pin10_ff;
    assign ctrl_bit11_pin = pin11_ff;
    assign inbound_done_strobe = strobe_ff;
    assign outbound_done_strobe = strobe_ff;
    assign aux_input_sel = insel_ff;
endmodule
`default_nettype wire

// *** design/csp_pkg.sv ***
// Purpose: shared constants and types for the codec serial port block
// Assumes: APB register window of 32-bit words, byte addressed
// Notes: the shift clock is sampled, never used as a clock
package csp_pkg;

    localparam int unsigned APB_AW = 8;
    localparam int unsigned APB_DW = 32;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TXWORD = 8'h04;
    localparam logic [7:0] REG_RXWORD = 8'h08;
    localparam logic [7:0] REG_CTLWORD = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_MASK = 8'h14;
    localparam logic [7:0] REG_STATE = 8'h18;

    // serial framing
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] LAST_WORD_BIT = 4'hF;
    localparam logic [CNT_W-1:0] LAST_BYTE_BIT = 4'h7;
    localparam logic [CNT_W-1:0] SECOND_BYTE_BIT = 4'h8;
    localparam logic [1:0] SEC_REQ_CODE = 2'h3;

    // control word (received serially) field positions
    localparam int unsigned CTLW_INSEL_BIT = 4;
    localparam int unsigned CTLW_BIT_TEN = 10;
    localparam int unsigned CTLW_BIT_ELEVEN = 11;
    localparam logic [WORD_BITS-1:0] CTLW_RESET = 16'h0000;
    localparam logic [WORD_BITS-1:0] TXWORD_RESET = 16'h0000;

    // software control register
    localparam int unsigned CTRL_RUN_BIT = 0;

    // interrupt status / mask layout
    localparam int unsigned IRQ_BITS = 2;
    localparam int unsigned IRQ_WORD_BIT = 0;
    localparam int unsigned IRQ_CTRL_BIT = 1;
    localparam logic [IRQ_BITS-1:0] IRQ_RESET = 2'h0;

    typedef enum logic [1:0] {
        CSP_IDLE,
        CSP_XFER,
        CSP_HOLD
    } csp_state_t;

endpackage

// *** design/csp_sync.sv ***
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to pclk
// Notes: only the second stage leaves the module
`timescale 1ns/1ps
`default_nettype none
module csp_sync #(
    parameter int unsigned W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    initial begin
        if (W < 1) begin
            $error("csp_sync: W must be at least 1");
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule
`default_nettype wire

// *** design/csp_shift.sv ***
// Purpose: parallel-load shift register, msb first
// Assumes: load has priority over shift
// Notes: shared by the inbound and outbound serial paths
`timescale 1ns/1ps
`default_nettype none
module csp_shift #(
    parameter int unsigned W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic shift_en,
    input wire logic ser_in,
    output logic [W-1:0] par_q,
    output logic msb
);

    logic [W-1:0] sh_ff;
    logic [W-1:0] nxt_sh;

    initial begin
        if (W < 2) begin
            $error("csp_shift: W must be at least 2");
        end
    end

    always_comb begin
        nxt_sh = sh_ff;
        if (load) begin
            nxt_sh = load_val;
        end else if (shift_en) begin
            nxt_sh = {sh_ff[W-2:0], ser_in};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ff <= '0;
        end else begin
            sh_ff <= nxt_sh;
        end
    end

    assign par_q = sh_ff;
    assign msb = sh_ff[W-1];

endmodule
`default_nettype wire

// *** verification/csp_port_chk.sv ***
// Purpose: pin checks of the serial port
// Assumes: 25 pclk per shift period
// Notes: mode is read from aux_frame_sync_oe
`timescale 1ns/1ps
`default_nettype none
module csp_port_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic serial_out_line,
    input wire logic inbound_frame_sync,
    input wire logic outbound_frame_sync,
    input wire logic aux_serial_data_pin,
    input wire logic aux_frame_sync_o,
    input wire logic aux_frame_sync_oe,
    input wire logic ctrl_bit10_pin,
    input wire logic ctrl_bit11_pin,
    input wire logic inbound_done_strobe,
    input wire logic outbound_done_strobe
);
    // two pclk of slack each way, the shift clock is only sampled
    localparam int LEN_LO = 398;
    localparam int LEN_HI = 402;
    logic [9:0] lo_ff, nxt_lo;
    logic [6:0] st_ff, nxt_st;
    logic pin_ff, nxt_pin;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_lo = aux_frame_sync_o ? 10'h000 : lo_ff + 10'h001;
        nxt_pin = aux_serial_data_pin;
        nxt_st = st_ff + {6'h00, ~&st_ff};
        if (aux_serial_data_pin != pin_ff) nxt_st = 7'h00;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_ff <= 10'h000;
            st_ff <= 7'h00;
            pin_ff <= 1'b0;
        end else begin
            lo_ff <= nxt_lo;
            st_ff <= nxt_st;
            pin_ff <= nxt_pin;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence dual_s;
        aux_frame_sync_oe [*3];
    endsequence
    sequence wb_s;
        !aux_frame_sync_oe [*3];
    endsequence
    reset_clear_a: assert property ($rose(presetn) |->
        !ctrl_bit10_pin && !ctrl_bit11_pin) else $error("ctrl pin not clear");
    ten_wb_low_a: assert property (wb_s |-> !ctrl_bit10_pin)
        else $error("bit ten pin driven outside dual mode");
    eleven_wb_low_a: assert property (wb_s |-> !ctrl_bit11_pin)
        else $error("bit eleven pin driven outside dual mode");
    strobe_dual_a: assert property (dual_s |-> inbound_done_strobe &&
        outbound_done_strobe) else $error("strobe low in dual mode");
    strobe_pair_a: assert property (
        inbound_done_strobe == outbound_done_strobe)
        else $error("done strobes differ");
    strobe_end_a: assert property (
        $fell(inbound_done_strobe) |-> $rose(inbound_frame_sync))
        else $error("strobe fell without end of transfer");
    aux_primary_a: assert property (
        !outbound_frame_sync |-> aux_frame_sync_o)
        else $error("aux sync low in primary frame");
    aux_follow_a: assert property (
        dual_s ##0 outbound_frame_sync |->
        aux_frame_sync_o == inbound_frame_sync)
        else $error("aux sync not following inbound sync");
    aux_len_a: assert property ($rose(aux_frame_sync_o) |->
        lo_ff >= LEN_LO && lo_ff <= LEN_HI) else $error("aux sync length");
    aux_data_a: assert property (
        $past(!aux_frame_sync_o) && !aux_frame_sync_o && st_ff[6] |->
        serial_out_line == aux_serial_data_pin)
        else $error("aux data not forwarded");
endmodule
`default_nettype wire

// *** verification/csp_dsp_model.sv ***
// Purpose: host serial port model
// Assumes: device frames, host supplies shift clock
// Notes: released data line toggles so stale bits cannot pass
`timescale 1ns/1ps
`default_nettype none
module csp_dsp_model (
    output logic shift_clk,
    output logic serial_in_line,
    input wire logic inbound_frame_sync,
    input wire logic serial_out_line,
    input wire logic [15:0] tx_word,
    output logic [15:0] rx_word
);
    int idx = -1;
    initial begin
        shift_clk = 1'b0;
        serial_in_line = 1'b0;
        rx_word = 16'h0000;
        #17;
        forever #62.5 shift_clk = ~shift_clk;
    end
    // reload only after a whole word, so the byte gap keeps position
    always @(negedge inbound_frame_sync) begin
        if (idx < 0) begin
            idx = 15;
            serial_in_line = tx_word[15];
        end
    end
    // bits change on rising edges, half a period before device sampling
    always @(posedge shift_clk) begin
        if (inbound_frame_sync == 1'b0 && idx >= 0) idx = idx - 1;
        if (idx >= 0) serial_in_line = tx_word[idx];
        else serial_in_line = ~serial_in_line;
    end
    always @(negedge shift_clk) begin
        if (inbound_frame_sync == 1'b0) begin
            rx_word = {rx_word[14:0], serial_out_line};
        end
    end
endmodule
`default_nettype wire

// *** verification/csp_port_tb.sv ***
// Purpose: self-checking bench for the codec serial port
// Assumes: free-running shift clock from the host model
// Notes: run is stopped after each awaited frame
`timescale 1ns/1ps
`default_nettype none
module csp_port_tb;
    import csp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic shift_clk, serial_in_line, serial_out_line, aux_serial_data_pin;
    logic inbound_frame_sync, outbound_frame_sync, wordbyte_strap, wb_sel;
    logic aux_frame_sync_o, aux_frame_sync_oe, ctrl_bit10_pin;
    logic ctrl_bit11_pin, inbound_done_strobe, outbound_done_strobe;
    logic aux_input_sel, last_err;
    logic [15:0] dsp_word, rx_word;
    logic [2:0] pins;
    int err_count = 0;
    int n_checks = 0;
    int low_n = 0;
    int last_low = 0;
    wire logic aux_frame_sync_i = aux_frame_sync_oe ? aux_frame_sync_o : wb_sel;
    csp_port i_csp_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .shift_clk,
        .serial_in_line, .serial_out_line, .inbound_frame_sync,
        .outbound_frame_sync, .aux_serial_data_pin, .wordbyte_strap,
        .aux_frame_sync_i, .aux_frame_sync_o, .aux_frame_sync_oe,
        .ctrl_bit10_pin, .ctrl_bit11_pin, .inbound_done_strobe,
        .outbound_done_strobe, .aux_input_sel);
    csp_dsp_model i_csp_dsp_model (.shift_clk, .serial_in_line,
        .inbound_frame_sync, .serial_out_line, .tx_word(dsp_word), .rx_word);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (inbound_done_strobe === 1'b0) begin
            low_n <= low_n + 1;
        end else if (low_n != 0) begin
            last_low <= low_n;
            low_n <= 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic hang();
        err_count++;
        $display("MISMATCH t=%0t wait timed out", $time);
        give_verdict();
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            if (n > 20) hang();
        end while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // pins are taken when irq rises: a deferred update would be missed
    task automatic frame(input logic [15:0] w, input logic [31:0] m);
        int n;
        n = 0;
        dsp_word <= w;
        apb(1'b1, REG_MASK, m);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        while (irq !== 1'b1) begin
            @(posedge pclk);
            n++;
            if (n > 2000) hang();
        end
        pins = {ctrl_bit11_pin, ctrl_bit10_pin, aux_input_sel};
        apb(1'b1, REG_CTRL, 32'h0000_0000);
        apb(1'b1, REG_STATUS, 32'h0000_0003);
        @(posedge pclk);
        chk(irq, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wordbyte_strap = 1'b0;
        wb_sel = 1'b1;
        aux_serial_data_pin = 1'b1;
        dsp_word = 16'h1230;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({ctrl_bit11_pin, ctrl_bit10_pin, inbound_done_strobe}, 32'h1);
        for (int a = 0; a < 24; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            chk(q, 32'h0);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk({q[30:0], last_err}, 32'h1);
        $display("test reset done");
        apb(1'b1, REG_TXWORD, 32'h0000_A5C3);
        frame(16'h1230, 32'h1);
        chk(rx_word, 32'hA5C3);
        apb(1'b0, REG_RXWORD, 32'h0);
        chk(q, 32'h1230);
        $display("test primary done");
        for (int k = 1; k >= 0; k--) begin
            aux_serial_data_pin <= k[0];
            frame(16'h0003, 32'h1);
            frame(k ? 16'h0C10 : 16'h0000, 32'h2);
            chk(pins, k ? 32'h7 : 32'h0);
            chk(rx_word, k ? 32'hFFFF : 32'h0);
            apb(1'b0, REG_CTLWORD, 32'h0);
            chk(q, k ? 32'h0C10 : 32'h0);
            $display("test secondary done");
        end
        wordbyte_strap <= 1'b1;
        for (int b = 1; b >= 0; b--) begin
            wb_sel <= b[0];
            frame(b ? 16'h5A3C : 16'hC35A, 32'h1);
            for (int n = 0; inbound_done_strobe !== 1'b1; n++) begin
                @(posedge pclk);
                if (n > 300) hang();
            end
            apb(1'b0, REG_RXWORD, 32'h0);
            chk(q, b ? 32'h5A3C : 32'hC35A);
            chk(b ? last_low inside {[23:27]} : last_low inside {[222:228]},
                32'h1);
            chk({aux_frame_sync_oe, pins[2:1]}, 32'h0);
            chk(rx_word, 32'hA5C3);
            $display("test word byte done");
        end
        give_verdict();
    end
endmodule
bind csp_port csp_port_chk i_csp_port_chk (.pclk, .presetn, .serial_out_line,
    .inbound_frame_sync, .outbound_frame_sync, .aux_serial_data_pin,
    .aux_frame_sync_o, .aux_frame_sync_oe, .ctrl_bit10_pin, .ctrl_bit11_pin,
    .inbound_done_strobe, .outbound_done_strobe);
`default_nettype wire
